// [verilog/svc_ctrl_status.sv]
// control, status and identification front end of the service unit
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "svc_defines.svh"

module svc_ctrl_status
#(
	// identification words, values are arbitrary
	parameter logic [31:0] MEMORY_TYPE_INFO_VALUE = 32'h00000001,
	parameter logic [31:0] PERIPHERAL_IDENT_4_VALUE    = 32'h00000000,
	parameter logic [31:0] PERIPHERAL_IDENT_0_VALUE    = 32'h00000011,
	parameter logic [31:0] PERIPHERAL_IDENT_1_VALUE    = 32'h00000022,
	parameter logic [31:0] PERIPHERAL_IDENT_2_VALUE    = 32'h00000033,
	parameter logic [31:0] PERIPHERAL_IDENT_3_VALUE    = 32'h00000000,
	parameter logic [31:0] COMPONENT_IDENT_0_VALUE    = 32'h00000044,
	parameter logic [31:0] COMPONENT_IDENT_1_VALUE    = 32'h00000055,
	parameter logic [31:0] COMPONENT_IDENT_2_VALUE    = 32'h00000066,
	parameter logic [31:0] COMPONENT_IDENT_3_VALUE    = 32'h00000077
)
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// register port
	input  wire logic [12:0]         reg_addr,
	input  wire svc_pkg::svc_size_t  reg_size,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [31:0]              reg_rdata,
	// protection state
	input  wire logic                pac_wr_protect,
	input  wire logic                device_protected,
	// operation launch
	output logic                     erase_start,
	output logic                     mem_selftest_start,
	output logic                     crc_start,
	output logic                     unit_soft_reset,
	output logic                     op_busy,
	// operation outcome
	input  wire logic                op_done,
	input  wire logic                op_fail,
	input  wire logic                op_bus_fault,
	input  wire logic                cold_plug_detect,
	// interrupt
	output logic                     irq
);
	import svc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations

	svc_core_t         core_reg;
	svc_core_t         core_next;

	svc_sel_t          dec_sel;
	logic [3:0]        dec_lanes;
	logic              dec_ok;

	logic              wr_ok;
	logic              rd_ok;
	logic              ctrl_wr;
	logic              stat_wr;
	logic              mask_wr;
	logic [7:0]        ctrl_byte;
	logic [`SVC_STAT_W-1:0] stat_clr;
	logic [`SVC_STAT_W-1:0] stat_set;
	logic [`SVC_STAT_W-1:0] stat_flags;
	logic              cmd_erase;
	logic              cmd_selftest;
	logic              cmd_crc;
	logic              cmd_srst;
	logic              viol_set;
	logic              done_set;
	logic [31:0]       word_value;
	logic              op_running;

	////////////////////////////////////////////////////////////////////////
	// address and size decode

	svc_lane_decode u_decode
	(
		.addr      (reg_addr),
		.size      (reg_size),
		.sel       (dec_sel),
		.lanes     (dec_lanes),
		.access_ok (dec_ok)
	);

	// byte lane mask of the lanes an access touches
	function automatic logic [31:0] lane_mask
	(
		input logic [3:0] l
	);
		return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
	endfunction : lane_mask

	// true when the decoded word and one of its byte lanes are both hit
	function automatic logic lane_hit
	(
		input svc_sel_t   got,
		input logic [3:0] lanes_in,
		input svc_sel_t   want,
		input logic [1:0] lane
	);
		return (got == want) && lanes_in[lane];
	endfunction : lane_hit

	// true while the sequencer sits in the given state
	function automatic logic state_is
	(
		input svc_core_t  c,
		input svc_state_t s
	);
		return (c.state == s);
	endfunction : state_is

	////////////////////////////////////////////////////////////////////////
	// write qualification

	// misaligned accesses are dropped whole
	// a misaligned access touches no lane, so it neither launches nor clears
	assign wr_ok = reg_wr && dec_ok;
	assign rd_ok = reg_rd && dec_ok;

	// control sits in lane 0 and status a in lane 1 of word 0
	assign ctrl_wr = wr_ok && lane_hit(dec_sel, dec_lanes, svc_sel_ctrl_stat, 2'h0)
		&& !pac_wr_protect;
	assign stat_wr = wr_ok && lane_hit(dec_sel, dec_lanes, svc_sel_ctrl_stat, 2'h1)
		&& !pac_wr_protect;

	// the interrupt mask is not protectable
	assign mask_wr = wr_ok && lane_hit(dec_sel, dec_lanes, svc_sel_mask, 2'h0);

	assign ctrl_byte = ctrl_wr ? reg_wdata[7:0] : 8'h00;

	// only written ones clear status flags
	assign stat_clr = stat_wr ? reg_wdata[8 +: `SVC_STAT_W] : '0;

	////////////////////////////////////////////////////////////////////////
	// command decode

	// a zero bit launches nothing
	assign cmd_srst     = ctrl_byte[`SVC_CTRL_SOFT_RESET];
	assign cmd_erase    = ctrl_byte[`SVC_CTRL_ERASE];
	assign cmd_selftest = ctrl_byte[`SVC_CTRL_SELFTEST];
	assign cmd_crc      = ctrl_byte[`SVC_CTRL_CRC];

	// self-test is refused while the device is protected
	assign viol_set = cmd_selftest && !cmd_srst && !cmd_erase && device_protected
		&& state_is(core_reg, svc_st_idle);

	// engine answers count only while an operation runs; late pulses belong to nothing
	assign op_running = state_is(core_reg, svc_st_busy);

	// completion of the running operation
	assign done_set = op_done && op_running;

	////////////////////////////////////////////////////////////////////////
	// status flags

	// failure and bus faults count only while an operation runs
	always_comb
	begin
		stat_set = '0;
		stat_set[`SVC_STAT_DONE]      = done_set;
		stat_set[`SVC_STAT_COLD_PLUG] = cold_plug_detect;
		stat_set[`SVC_STAT_BUS_FAULT] = op_bus_fault && op_running;
		stat_set[`SVC_STAT_FAIL]      = op_fail && op_running;
		stat_set[`SVC_STAT_PROT_VIOL] = viol_set;
	end

	svc_w1c_flags
	#(
		.W (`SVC_STAT_W)
	)
	u_status
	(
		.clk        (clk),
		.reset_n    (reset_n),
		.set_pulse  (stat_set),
		.clr_mask   (stat_clr),
		.soft_clear (core_reg.srst_pulse),
		.flags      (stat_flags)
	);

	////////////////////////////////////////////////////////////////////////
	// read mux

	// control reads as zero, identification words are constants
	always_comb
	begin
		word_value = 32'h00000000;
		unique case (dec_sel)
			svc_sel_ctrl_stat: word_value = {16'h0000, 3'b000, stat_flags, 8'h00};
			svc_sel_mask:      word_value = {27'h0000000, core_reg.mask};
			svc_sel_memory_type_info:   word_value = MEMORY_TYPE_INFO_VALUE;
			svc_sel_peripheral_ident_4:      word_value = PERIPHERAL_IDENT_4_VALUE;
			svc_sel_peripheral_ident_0:      word_value = PERIPHERAL_IDENT_0_VALUE;
			svc_sel_peripheral_ident_1:      word_value = PERIPHERAL_IDENT_1_VALUE;
			svc_sel_peripheral_ident_2:      word_value = PERIPHERAL_IDENT_2_VALUE;
			svc_sel_peripheral_ident_3:      word_value = PERIPHERAL_IDENT_3_VALUE;
			svc_sel_component_ident_0:      word_value = COMPONENT_IDENT_0_VALUE;
			svc_sel_component_ident_1:      word_value = COMPONENT_IDENT_1_VALUE;
			svc_sel_component_ident_2:      word_value = COMPONENT_IDENT_2_VALUE;
			svc_sel_component_ident_3:      word_value = COMPONENT_IDENT_3_VALUE;
			svc_sel_none:      word_value = 32'h00000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	// sequencer, launch pulses, mask and read data
	always_comb
	begin
		core_next                = core_reg;
		core_next.erase_pulse    = 1'b0;
		core_next.selftest_pulse = 1'b0;
		core_next.crc_pulse      = 1'b0;
		core_next.srst_pulse     = 1'b0;

		// read data stands only in the cycle after the strobe
		core_next.rdata = `SVC_RDATA_RESET;
		if (rd_ok)
		begin
			core_next.rdata = word_value & lane_mask(dec_lanes);
		end

		// mask register, identification words take no write
		if (mask_wr)
		begin
			core_next.mask = reg_wdata[4:0];
		end

		unique case (core_reg.state)
			svc_st_idle:
			begin
				// priority: reset, erase, self-test, crc
				// a refused self-test also holds back a crc written beside it
				if (cmd_srst)
				begin
					core_next.state      = svc_st_reset;
					core_next.srst_pulse = 1'b1;
				end
				else if (cmd_erase)
				begin
					core_next.state       = svc_st_busy;
					core_next.erase_pulse = 1'b1;
				end
				else if (cmd_selftest && !device_protected)
				begin
					core_next.state          = svc_st_busy;
					core_next.selftest_pulse = 1'b1;
				end
				else if (cmd_crc && !cmd_selftest)
				begin
					core_next.state     = svc_st_busy;
					core_next.crc_pulse = 1'b1;
				end
			end
			svc_st_busy:
			begin
				// new launches other than a soft reset are ignored until the running one ends
				if (cmd_srst)
				begin
					core_next.state      = svc_st_reset;
					core_next.srst_pulse = 1'b1;
				end
				else if (done_set)
				begin
					core_next.state = svc_st_idle;
				end
			end
			svc_st_reset:
			begin
				// one cycle in which flags, mask and engine are cleared
				core_next.state = svc_st_idle;
				core_next.mask  = `SVC_MASK_RESET;
			end
			default:
			begin
				core_next.state = svc_st_idle;
			end
		endcase

		// soft reset also drops a mask write of the same cycle
		if (cmd_srst)
		begin
			core_next.mask = `SVC_MASK_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	// launch pulses drop at once so nothing starts while reset is low
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			core_reg.state          <= svc_st_idle;
			core_reg.mask           <= `SVC_MASK_RESET;
			core_reg.rdata          <= `SVC_RDATA_RESET;
			core_reg.erase_pulse    <= 1'b0;
			core_reg.selftest_pulse <= 1'b0;
			core_reg.crc_pulse      <= 1'b0;
			core_reg.srst_pulse     <= 1'b0;
		end
		else
		begin
			core_reg <= core_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// data and launch outputs come straight from flops
	assign reg_rdata          = core_reg.rdata;
	assign erase_start        = core_reg.erase_pulse;
	assign mem_selftest_start = core_reg.selftest_pulse;
	assign crc_start          = core_reg.crc_pulse;
	assign unit_soft_reset    = core_reg.srst_pulse;
	assign op_busy            = op_running;

	// level interrupt while any unmasked flag is set
	assign irq = |(stat_flags & core_reg.mask);

endmodule : svc_ctrl_status

// [pkg/svc_defines.svh]
// offsets, field positions, reset values and widths of the service unit
`ifndef SVC_DEFINES_SVH
`define SVC_DEFINES_SVH

// byte offsets of the register map
`define SVC_OFS_CTRL        13'h0000
`define SVC_OFS_STATUS_A    13'h0001
`define SVC_OFS_INT_MASK    13'h0020
`define SVC_OFS_MEMORY_TYPE_INFO     13'h1FCC
`define SVC_OFS_PERIPHERAL_IDENT_4        13'h1FD0
`define SVC_OFS_PERIPHERAL_IDENT_0        13'h1FE0
`define SVC_OFS_PERIPHERAL_IDENT_1        13'h1FE4
`define SVC_OFS_PERIPHERAL_IDENT_2        13'h1FE8
`define SVC_OFS_PERIPHERAL_IDENT_3        13'h1FEC
`define SVC_OFS_COMPONENT_IDENT_0        13'h1FF0
`define SVC_OFS_COMPONENT_IDENT_1        13'h1FF4
`define SVC_OFS_COMPONENT_IDENT_2        13'h1FF8
`define SVC_OFS_COMPONENT_IDENT_3        13'h1FFC

// control bit positions
`define SVC_CTRL_SOFT_RESET 0
`define SVC_CTRL_CRC        2
`define SVC_CTRL_SELFTEST   3
`define SVC_CTRL_ERASE      4

// status a bit positions
`define SVC_STAT_DONE       0
`define SVC_STAT_COLD_PLUG  1
`define SVC_STAT_BUS_FAULT  2
`define SVC_STAT_FAIL       3
`define SVC_STAT_PROT_VIOL  4
`define SVC_STAT_W          5

// reset values
`define SVC_STATUS_RESET    5'h00
`define SVC_MASK_RESET      5'h00
`define SVC_RDATA_RESET     32'h00000000

`endif

// [pkg/svc_pkg.sv]
// types shared by the service unit control and status front end
package svc_pkg;

	// access size of one register bus request
	typedef enum logic [1:0]
	{
		svc_size_byte = 2'b00,
		svc_size_half = 2'b01,
		svc_size_word = 2'b10
	} svc_size_t;

	// register selected by the address decoder
	typedef enum logic [3:0]
	{
		svc_sel_none,
		svc_sel_ctrl_stat,
		svc_sel_mask,
		svc_sel_memory_type_info,
		svc_sel_peripheral_ident_4,
		svc_sel_peripheral_ident_0,
		svc_sel_peripheral_ident_1,
		svc_sel_peripheral_ident_2,
		svc_sel_peripheral_ident_3,
		svc_sel_component_ident_0,
		svc_sel_component_ident_1,
		svc_sel_component_ident_2,
		svc_sel_component_ident_3
	} svc_sel_t;

	// operation sequencer, gray along idle, busy, reset
	typedef enum logic [1:0]
	{
		svc_st_idle  = 2'b00,
		svc_st_busy  = 2'b01,
		svc_st_reset = 2'b11
	} svc_state_t;

	// complete state of the core
	typedef struct packed
	{
		svc_state_t  state;
		logic [4:0]  mask;
		logic [31:0] rdata;
		logic        erase_pulse;
		logic        selftest_pulse;
		logic        crc_pulse;
		logic        srst_pulse;
	} svc_core_t;

endpackage : svc_pkg

// [verilog/svc_lane_decode.sv]
// address and access size decoder of the service unit register port
`timescale 1ns/1ps
`include "svc_defines.svh"

module svc_lane_decode
(
	// request
	input  wire logic [12:0]          addr,
	input  wire svc_pkg::svc_size_t   size,
	// decode result
	output svc_pkg::svc_sel_t         sel,
	output logic [3:0]                lanes,
	output logic                      access_ok
);
	import svc_pkg::*;

	// byte lanes touched by a naturally aligned access, zero when misaligned
	function automatic logic [3:0] lanes_of
	(
		input svc_size_t sz,
		input logic [1:0] ofs
	);
		logic [3:0] l;
		l = 4'h0;
		unique case (sz)
			svc_size_byte: l = 4'h1 << ofs;
			svc_size_half: l = ofs[0] ? 4'h0 : (ofs[1] ? 4'hC : 4'h3);
			svc_size_word: l = (ofs == 2'h0) ? 4'hF : 4'h0;
			default:       l = 4'h0;
		endcase
		return l;
	endfunction : lanes_of

	// word select from the aligned word address
	always_comb
	begin
		unique case ({addr[12:2], 2'b00})
			`SVC_OFS_CTRL:     sel = svc_sel_ctrl_stat;
			`SVC_OFS_INT_MASK: sel = svc_sel_mask;
			`SVC_OFS_MEMORY_TYPE_INFO:  sel = svc_sel_memory_type_info;
			`SVC_OFS_PERIPHERAL_IDENT_4:     sel = svc_sel_peripheral_ident_4;
			`SVC_OFS_PERIPHERAL_IDENT_0:     sel = svc_sel_peripheral_ident_0;
			`SVC_OFS_PERIPHERAL_IDENT_1:     sel = svc_sel_peripheral_ident_1;
			`SVC_OFS_PERIPHERAL_IDENT_2:     sel = svc_sel_peripheral_ident_2;
			`SVC_OFS_PERIPHERAL_IDENT_3:     sel = svc_sel_peripheral_ident_3;
			`SVC_OFS_COMPONENT_IDENT_0:     sel = svc_sel_component_ident_0;
			`SVC_OFS_COMPONENT_IDENT_1:     sel = svc_sel_component_ident_1;
			`SVC_OFS_COMPONENT_IDENT_2:     sel = svc_sel_component_ident_2;
			`SVC_OFS_COMPONENT_IDENT_3:     sel = svc_sel_component_ident_3;
			default:           sel = svc_sel_none;
		endcase
	end

	// 8, 16 and 32 bit accesses, each quarter and half reachable
	assign lanes     = lanes_of(size, addr[1:0]);
	assign access_ok = (lanes != 4'h0);

endmodule : svc_lane_decode

// [verilog/svc_w1c_flags.sv]
// sticky status flags, set by hardware, cleared by writing one
`timescale 1ns/1ps

module svc_w1c_flags
#(
	parameter int W = 5
)
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// events and clears
	input  wire logic [W-1:0] set_pulse,
	input  wire logic [W-1:0] clr_mask,
	input  wire logic         soft_clear,
	// flags
	output logic [W-1:0]      flags
);
	typedef struct packed
	{
		logic [W-1:0] flags;
	} svc_flag_state_t;

	svc_flag_state_t st_reg;
	svc_flag_state_t st_next;

	// a set in the same cycle as its clear wins; zero writes change nothing
	always_comb
	begin
		st_next = st_reg;
		st_next.flags = (st_reg.flags & ~clr_mask) | set_pulse;
		if (soft_clear)
		begin
			st_next.flags = '0;
		end
	end

	// state register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign flags = st_reg.flags;

endmodule : svc_w1c_flags

// [testbench/svc_engine_model.sv]
// behavioural model of the operation engine that sits behind the launch pulses
`timescale 1ns/1ps

module svc_engine_model
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// launch and commanded outcome: 0 clean, 1 failure, 2 bus error
	input  wire logic       start,
	input  wire logic [1:0] outcome,
	input  wire logic [3:0] lat,
	// answers towards the unit
	output logic            op_done,
	output logic            op_fail,
	output logic            op_bus_fault
);
	logic [3:0] cnt;

	////////////////////////////////////////////////////////////////
	// count down from launch; a fault is reported just before completion when the latency is 3 or more
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt          <= 4'h0;
			op_done      <= 1'b0;
			op_fail      <= 1'b0;
			op_bus_fault <= 1'b0;
		end
		else
		begin
			cnt          <= start ? lat : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
			op_fail      <= cnt == 4'h3 && outcome == 2'h1;
			op_bus_fault <= cnt == 4'h3 && outcome == 2'h2;
			op_done      <= cnt == 4'h2 || (start && lat < 4'h2); // a short latency still completes
		end
	end
endmodule : svc_engine_model

// [testbench/svc_ctrl_status_sva.sv]
// port assertions of the service unit control and status front end
`timescale 1ns/1ps

module svc_ctrl_status_sva
(
	// clock and reset
	input wire logic               clk,
	input wire logic               reset_n,
	// register port
	input wire logic [12:0]        reg_addr,
	input wire svc_pkg::svc_size_t reg_size,
	input wire logic [31:0]        reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [31:0]        reg_rdata,
	// protection, launch and outcome
	input wire logic               pac_wr_protect,
	input wire logic               device_protected,
	input wire logic               erase_start,
	input wire logic               mem_selftest_start,
	input wire logic               crc_start,
	input wire logic               unit_soft_reset,
	input wire logic               op_busy,
	input wire logic               op_done,
	input wire logic               op_fail,
	input wire logic               op_bus_fault,
	input wire logic               cold_plug_detect,
	input wire logic               irq
);
	import svc_pkg::*;
	logic ctl_ok;
	logic any_go;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// a control byte write that is allowed to launch something
	assign ctl_ok = reg_wr && reg_addr == 13'h0000 && reg_size == svc_size_byte && !pac_wr_protect
		&& !op_busy && !unit_soft_reset;
	assign any_go = erase_start || mem_selftest_start || crc_start || unit_soft_reset;

	////////////////////////////////////////////////////////////////
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
		else $error("read data not zero outside read answer");
	a_erase_launch: assert property (ctl_ok && reg_wdata[4] && !reg_wdata[0] |=> erase_start && op_busy)
		else $error("erase not launched");
	a_selftest_launch: assert property (ctl_ok && reg_wdata[4:0] == 5'h08 && !device_protected
		|=> mem_selftest_start && op_busy)
		else $error("self-test not launched");
	a_crc_launch: assert property (ctl_ok && reg_wdata[4:0] == 5'h04 |=> crc_start ##1 !crc_start)
		else $error("crc launch not a single pulse");
	a_soft_reset: assert property (reg_wr && reg_addr == 13'h0000 && reg_size == svc_size_byte
		&& reg_wdata[0] && !pac_wr_protect && !unit_soft_reset
		|=> unit_soft_reset && !erase_start ##1 !unit_soft_reset)
		else $error("soft reset pulse wrong");
	a_zero_quiet: assert property (reg_wr && reg_wdata[4:0] == 5'h00 |=> !any_go)
		else $error("zero write launched something");
	a_pac_block: assert property (reg_wr && pac_wr_protect |=> !any_go)
		else $error("protected write launched something");
	a_prot_refuse: assert property (ctl_ok && reg_wdata[4:0] == 5'h08 && device_protected
		|=> !mem_selftest_start && !op_busy)
		else $error("self-test launched while protected");
	a_busy_hold: assert property (op_busy && !op_done && !reg_wr |=> op_busy)
		else $error("busy dropped before completion");
	a_done_release: assert property (op_busy && op_done |=> !op_busy)
		else $error("busy held after completion");
endmodule : svc_ctrl_status_sva

bind svc_ctrl_status svc_ctrl_status_sva u_svc_ctrl_status_sva
(
	.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_size(reg_size), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pac_wr_protect(pac_wr_protect),
	.device_protected(device_protected), .erase_start(erase_start), .mem_selftest_start(mem_selftest_start),
	.crc_start(crc_start), .unit_soft_reset(unit_soft_reset), .op_busy(op_busy), .op_done(op_done),
	.op_fail(op_fail), .op_bus_fault(op_bus_fault), .cold_plug_detect(cold_plug_detect), .irq(irq)
);

// [testbench/tb.sv]
// self-checking bench of the service unit control and status front end
`timescale 1ns/1ps

module tb;
	import svc_pkg::*;
	logic        clk, reset_n, reg_wr, reg_rd, pac_wr_protect, device_protected, cold_plug_detect;
	logic        erase_start, mem_selftest_start, crc_start, unit_soft_reset, op_busy, irq;
	logic        op_done, op_fail, op_bus_fault;
	logic [12:0] reg_addr;
	svc_size_t   reg_size;
	logic [31:0] reg_wdata, reg_rdata;
	logic [1:0]  outcome;
	logic [3:0]  lat;
	int          n_fail, comparisons, cyc;
	logic [12:0] id_ofs [10] = '{13'h1FCC, 13'h1FD0, 13'h1FE0, 13'h1FE4, 13'h1FE8, 13'h1FEC, 13'h1FF0,
		13'h1FF4, 13'h1FF8, 13'h1FFC};
	logic [31:0] id_val [10] = '{32'h1, 32'h0, 32'h11, 32'h22, 32'h33, 32'h0, 32'h44, 32'h55, 32'h66, 32'h77};

	svc_ctrl_status u_svc_ctrl_status
	(
		.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_size(reg_size), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pac_wr_protect(pac_wr_protect),
		.device_protected(device_protected), .erase_start(erase_start), .mem_selftest_start(mem_selftest_start),
		.crc_start(crc_start), .unit_soft_reset(unit_soft_reset), .op_busy(op_busy), .op_done(op_done),
		.op_fail(op_fail), .op_bus_fault(op_bus_fault), .cold_plug_detect(cold_plug_detect), .irq(irq)
	);
	svc_engine_model u_svc_engine_model
	(
		.clk(clk), .reset_n(reset_n), .start(erase_start || mem_selftest_start || crc_start),
		.outcome(outcome), .lat(lat), .op_done(op_done), .op_fail(op_fail), .op_bus_fault(op_bus_fault)
	);

	////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			n_fail++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one-cycle write strobe
	task automatic wr(input logic [12:0] a, input svc_size_t s, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_size  <= s;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// one-cycle read strobe, data checked in the following cycle
	task automatic rd(input logic [12:0] a, input svc_size_t s, input logic [31:0] exp, input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_size <= s;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, exp, reg_rdata);
	endtask : rd

	// status flags sit in lane 1
	task automatic rs(input logic [4:0] f, input string what);
		rd(13'h001, svc_size_byte, {16'h0, 3'h0, f, 8'h0}, what);
	endtask : rs

	// launch, wait for completion, check the resulting flags
	task automatic run(input logic [31:0] d, input logic [1:0] o, input logic [3:0] l, input logic [4:0] f);
		int i;
		outcome <= o;
		lat     <= l;
		wr(13'h000, svc_size_byte, d);
		chk("busy", 32'h1, {31'h0, op_busy});
		i = 0;
		while (op_busy !== 1'b0 && i < 50)
		begin
			@(posedge clk);
			#1;
			i++;
		end
		rs(f, "flags after operation");
	endtask : run

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{clk, reset_n, reg_wr, reg_rd, pac_wr_protect, device_protected, cold_plug_detect} = 7'h00;
		reg_addr  = 13'h0000;
		reg_size  = svc_size_byte;
		reg_wdata = 32'h00000000;
		outcome   = 2'h0;
		lat       = 4'h3;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		rs(5'h00, "status reset");
		rd(13'h020, svc_size_byte, 32'h0, "mask reset");
		for (int i = 0; i < 10; i++) rd(id_ofs[i], svc_size_word, id_val[i], "ident word");
		wr(13'h1FE0, svc_size_word, 32'hFFFFFFFF);
		rd(13'h1FE0, svc_size_word, 32'h11, "ident after write");
		rd(13'h0100, svc_size_word, 32'h0, "unmapped");
		run(32'h10, 2'h0, 4'h3, 5'h01);
		wr(13'h001, svc_size_byte, 32'h0);
		rs(5'h01, "zero write kept flag");
		wr(13'h020, svc_size_byte, 32'h01);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(13'h001, svc_size_byte, 32'h0100);
		chk("irq cleared", 32'h0, {31'h0, irq});
		run(32'h08, 2'h1, 4'h9, 5'h09);
		wr(13'h001, svc_size_byte, 32'h0800);
		rs(5'h01, "fail cleared");
		run(32'h04, 2'h2, 4'h3, 5'h05);
		wr(13'h000, svc_size_half, 32'h1F00);
		rs(5'h00, "half clear");
		@(posedge clk);
		device_protected <= 1'b1;
		wr(13'h000, svc_size_byte, 32'h08);
		chk("refused self-test", 32'h0, {31'h0, op_busy});
		rd(13'h000, svc_size_word, 32'h1000, "word read");
		rd(13'h000, svc_size_half, 32'h1000, "half read");
		wr(13'h001, svc_size_byte, 32'h1000);
		rs(5'h00, "violation cleared");
		@(posedge clk);
		device_protected <= 1'b0;
		cold_plug_detect <= 1'b1;
		@(posedge clk);
		cold_plug_detect <= 1'b0;
		pac_wr_protect   <= 1'b1;
		wr(13'h000, svc_size_byte, 32'h10);
		wr(13'h001, svc_size_byte, 32'h0200);
		chk("blocked erase", 32'h0, {31'h0, op_busy});
		rs(5'h02, "blocked clear");
		wr(13'h020, svc_size_byte, 32'h02);
		rd(13'h020, svc_size_byte, 32'h02, "mask under protection");
		@(posedge clk);
		pac_wr_protect <= 1'b0;
		wr(13'h020, svc_size_byte, 32'h1F);
		chk("irq cold plug", 32'h1, {31'h0, irq});
		wr(13'h000, svc_size_byte, 32'h01);
		rs(5'h00, "soft reset flags");
		rd(13'h020, svc_size_byte, 32'h0, "soft reset mask");
		chk("irq after soft reset", 32'h0, {31'h0, irq});
		conclude();
	end
endmodule : tb
